// *** include/txvco_pkg.sv ***
// Constants, field layouts and types for the transmitter and oscillator settings bank
package txvco_pkg;
    localparam int ADDR_W = 6;
    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_IRQ_STATUS = 4'h1;
    localparam logic [3:0] IDX_IRQ_MASK = 4'h2;
    localparam logic [3:0] IDX_TX_SETTINGS = 4'h7;
    localparam logic [3:0] IDX_OSC_BAND = 4'h8;
    // Field positions
    localparam int TX_LO_LSB = 0;
    localparam int TX_HI_LSB = 4;
    localparam int TX_RAMP_LSB = 8;
    localparam int TX_OFS_I_LSB = 10;
    localparam int TX_OFS_Q_LSB = 15;
    localparam int TX_USED_W = 20;
    localparam int OSC_BAND_LSB = 0;
    localparam int OSC_ERR_BIT = 4;
    localparam int CTRL_TEST_BIT = 0;
    localparam int IRQ_CAL_ERR_BIT = 0;
    localparam int IRQ_RAMP_DONE_BIT = 1;
    localparam int IRQ_W = 2;
    // Reset values
    localparam logic [3:0] TX_LO_GAIN_RESET = 4'hF;
    localparam logic [3:0] TX_HI_GAIN_RESET = 4'h0;
    localparam logic [1:0] TX_RAMP_RESET = 2'h0;
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int RAMP_STEP_NS = 1000;
    localparam int RAMP_TIME_NS = 1000;
    localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAMP_TIME_CYC = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 7;

    typedef struct packed {
        logic       on;
        logic [3:0] val;   // Sign in the top bit, magnitude below
    } leak_ofs_t;

    typedef struct packed {
        leak_ofs_t  q;
        leak_ofs_t  i;
        logic [1:0] ramp;
        logic [3:0] hi_gain;
        logic [3:0] lo_gain;
    } tx_settings_t;

    typedef struct packed {
        leak_ofs_t  q;
        leak_ofs_t  i;
    } leak_pair_t;

    typedef enum logic [1:0] {
        RAMP_IDLE = 2'b00,
        RAMP_WAIT = 2'b01,
        RAMP_RISE = 2'b10,
        RAMP_FULL = 2'b11
    } ramp_state_t;
endpackage

// *** src/tx_and_vco_settings_regs.sv ***
// Transmitter and oscillator settings register bank with Avalon-MM slave
// What this block does
// R1: Bits 0-3 set low-power output gain
// R2: Bits 4-7 set high-power output gain
// R3: Bits 8-9 pick ramp delay 1-4 us
// R4: Ramp itself always lasts one microsecond
// R5: Test mode writes drive leakage offsets directly
// R6: Normal mode reads return calibrated leakage offsets
// R7: Off gives zero; sign, magnitude in 2.5 uA
// R8: I offset value bits 10-13, enable 14
// R9: Q offset value bits 15-18, enable 19
// R10: Test mode write forces oscillator band
// R11: Normal mode reads calibrated band, 0000 highest
// R12: Host sets compensation near 640 over modulus
// R13: Host sends zeros in divider's top bits
// R14: Calibration error flag in oscillator bit 4
// R15: Transmitter bits 20-23 written and held zero
// R16: Reset: low gain all ones, rest zero
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
module tx_and_vco_settings_regs
    import txvco_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic [ADDR_W-1:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [3:0] BYTEENABLE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    output logic IRQ,
    input wire logic TX_ENABLE_PIN,
    input wire leak_pair_t CAL_LEAK,
    input wire logic [3:0] CAL_BAND,
    input wire logic CAL_DONE,
    input wire logic CAL_ERROR,
    output logic [3:0] LOW_POWER_TX_OUTPUT_GAIN,
    output logic [3:0] HIGH_POWER_TX_OUTPUT_GAIN,
    output logic signed [4:0] I_LEAK_OFFSET_STEPS,
    output logic signed [4:0] Q_LEAK_OFFSET_STEPS,
    output logic [3:0] OSCILLATOR_BAND,
    output logic TX_RAMP_ACTIVE,
    output logic TX_OUTPUT_ON
);
    // Offset in 2.5 uA steps: off is zero, otherwise +-(magnitude+1)
    function automatic logic signed [4:0] leak_steps(input leak_ofs_t c);
        logic signed [4:0] mag;
        mag = 5'(c.val[2:0]) + 5'sh01;
        if (!c.on) begin
            leak_steps = 5'sh00;
        end else if (c.val[3]) begin
            leak_steps = -mag;
        end else begin
            leak_steps = mag;
        end
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        be_merge = r;
    endfunction

    // Bus slave: one wait cycle, so with CE held high every access ends at the second edge
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic test_q, test_d;
    tx_settings_t tx_q, tx_d;
    logic [3:0] band_q, band_d;
    logic vcerr_q, vcerr_d;
    logic [IRQ_W-1:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
    ramp_state_t ramp_q, ramp_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [1:0] txen_sync_q;
    logic [1:0] txen_sync_d;
    logic [3:0] idx;
    logic wr_go, rd_go, ramp_done;
    logic [31:0] tx_word, osc_word, wmerge;
    leak_pair_t leak_view;

    assign idx = ADDRESS[ADDR_W-1:2];
    // A frozen clock enable keeps the access pending, so no answer is ever given without its effect
    assign WAITREQUEST = (READ || WRITE) && (!ack_q || !CE);
    // Writes land at the edge that completes the access, never earlier
    assign wr_go = CE && WRITE && ack_q;
    assign rd_go = CE && READ && !ack_q;

    always_comb begin
        leak_view = test_q ? leak_pair_t'({tx_q.q, tx_q.i}) : CAL_LEAK;  // see R5 R6
        tx_word = {12'h000, leak_view, tx_q.ramp, tx_q.hi_gain, tx_q.lo_gain};  // see R15
        osc_word = {27'h0000000, vcerr_q, (test_q ? band_q : CAL_BAND)};  // see R11 R14
    end

    always_comb begin
        ack_d = ack_q;
        rdata_d = rdata_q;
        test_d = test_q;
        tx_d = tx_q;
        band_d = band_q;
        vcerr_d = vcerr_q;
        irq_mask_d = irq_mask_q;
        irq_st_d = irq_st_q;
        wmerge = 32'h00000000;
        if (CE) begin
            ack_d = (READ || WRITE) && !ack_q;
            if (rd_go) begin
                case (idx)
                    IDX_CTRL: rdata_d = {31'h00000000, test_q};
                    IDX_IRQ_STATUS: rdata_d = {30'h00000000, irq_st_q};
                    IDX_IRQ_MASK: rdata_d = {30'h00000000, irq_mask_q};
                    IDX_TX_SETTINGS: rdata_d = tx_word;
                    IDX_OSC_BAND: rdata_d = osc_word;
                    default: rdata_d = 32'h00000000;
                endcase
            end
            if (wr_go) begin
                case (idx)
                    IDX_CTRL: begin
                        wmerge = be_merge({31'h00000000, test_q}, WRITEDATA, BYTEENABLE);
                        test_d = wmerge[CTRL_TEST_BIT];
                    end
                    IDX_IRQ_MASK: begin
                        wmerge = be_merge({30'h00000000, irq_mask_q}, WRITEDATA, BYTEENABLE);
                        irq_mask_d = wmerge[IRQ_W-1:0];
                    end
                    IDX_IRQ_STATUS: begin
                        wmerge = be_merge(32'h00000000, WRITEDATA, BYTEENABLE);
                        irq_st_d = irq_st_q & ~wmerge[IRQ_W-1:0];
                    end
                    IDX_TX_SETTINGS: begin
                        wmerge = be_merge({12'h000, tx_q}, WRITEDATA, BYTEENABLE);
                        tx_d.lo_gain = wmerge[TX_LO_LSB +: 4];  // see R1
                        tx_d.hi_gain = wmerge[TX_HI_LSB +: 4];  // see R2
                        tx_d.ramp = wmerge[TX_RAMP_LSB +: 2];  // see R3
                        if (test_q) begin
                            tx_d.i = wmerge[TX_OFS_I_LSB +: 5];  // see R8
                            tx_d.q = wmerge[TX_OFS_Q_LSB +: 5];  // see R9
                        end
                    end
                    IDX_OSC_BAND: begin
                        wmerge = be_merge({28'h0000000, band_q}, WRITEDATA, BYTEENABLE);
                        if (test_q) begin
                            band_d = wmerge[OSC_BAND_LSB +: 4];  // see R10
                        end
                    end
                    default: wmerge = 32'h00000000;
                endcase
            end
            // A completing calibration clears the old error; a new error is sticky until then
            if (CAL_DONE) begin
                vcerr_d = 1'b0;
            end
            if (CAL_ERROR) begin
                vcerr_d = 1'b1;  // see R14
            end
            // Hardware set wins over a software clear in the same cycle
            if (CAL_ERROR) begin
                irq_st_d[IRQ_CAL_ERR_BIT] = 1'b1;
            end
            if (ramp_done) begin
                irq_st_d[IRQ_RAMP_DONE_BIT] = 1'b1;
            end
        end
    end

    // Ramp sequencer: programmed delay, then a fixed one microsecond rise
    always_comb begin
        ramp_d = ramp_q;
        cnt_d = cnt_q;
        ramp_done = 1'b0;
        txen_sync_d = CE ? {txen_sync_q[0], TX_ENABLE_PIN} : txen_sync_q;
        if (CE) begin
            case (ramp_q)
                RAMP_IDLE: begin
                    if (txen_sync_q[1]) begin
                        ramp_d = RAMP_WAIT;
                        cnt_d = CNT_W'((32'(tx_q.ramp) + 32'd1) * RAMP_STEP_CYC - 1);  // see R3
                    end
                end
                RAMP_WAIT: begin
                    if (!txen_sync_q[1]) begin
                        ramp_d = RAMP_IDLE;
                    end else if (cnt_q == '0) begin
                        ramp_d = RAMP_RISE;
                        cnt_d = CNT_W'(RAMP_TIME_CYC - 1);  // see R4
                    end else begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
                RAMP_RISE: begin
                    if (!txen_sync_q[1]) begin
                        ramp_d = RAMP_IDLE;
                    end else if (cnt_q == '0) begin
                        ramp_d = RAMP_FULL;
                        ramp_done = 1'b1;
                    end else begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
                RAMP_FULL: begin
                    if (!txen_sync_q[1]) begin
                        ramp_d = RAMP_IDLE;
                    end
                end
                default: ramp_d = RAMP_IDLE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
            test_q <= 1'b0;
            tx_q <= '{lo_gain: TX_LO_GAIN_RESET, hi_gain: TX_HI_GAIN_RESET, ramp: TX_RAMP_RESET,
                      i: '0, q: '0};  // see R16
            band_q <= 4'h0;
            vcerr_q <= 1'b0;
            irq_st_q <= '0;
            irq_mask_q <= '0;
            ramp_q <= RAMP_IDLE;
            cnt_q <= '0;
            txen_sync_q <= 2'b00;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            test_q <= test_d;
            tx_q <= tx_d;
            band_q <= band_d;
            vcerr_q <= vcerr_d;
            irq_st_q <= irq_st_d;
            irq_mask_q <= irq_mask_d;
            ramp_q <= ramp_d;
            cnt_q <= cnt_d;
            txen_sync_q <= txen_sync_d;
        end
    end

    // Outputs: gains straight from flops, offsets decoded and band taken from the active source
    assign READDATA = rdata_q;
    assign IRQ = |(irq_st_q & irq_mask_q);
    assign LOW_POWER_TX_OUTPUT_GAIN = tx_q.lo_gain;  // see R1
    assign HIGH_POWER_TX_OUTPUT_GAIN = tx_q.hi_gain;  // see R2
    assign I_LEAK_OFFSET_STEPS = leak_steps(leak_view.i);  // see R7 R8
    assign Q_LEAK_OFFSET_STEPS = leak_steps(leak_view.q);  // see R7 R9
    assign OSCILLATOR_BAND = test_q ? band_q : CAL_BAND;  // see R10 R11
    assign TX_RAMP_ACTIVE = (ramp_q == RAMP_RISE);
    assign TX_OUTPUT_ON = (ramp_q == RAMP_FULL);

    property p_low_gain;  // see R1
        @(posedge REF_CLK) disable iff (SRST)
        (wr_go && idx == IDX_TX_SETTINGS && BYTEENABLE[0]) |=> LOW_POWER_TX_OUTPUT_GAIN == $past(WRITEDATA[3:0]);
    endproperty
    a_low_gain: assert property (p_low_gain) else $error("low gain not taken from bits 0-3");  // see R1
    property p_high_gain;
        @(posedge REF_CLK) disable iff (SRST)
        (wr_go && idx == IDX_TX_SETTINGS && BYTEENABLE[0]) |=> HIGH_POWER_TX_OUTPUT_GAIN == $past(WRITEDATA[7:4]);
    endproperty
    a_high_gain: assert property (p_high_gain) else $error("high gain not taken from bits 4-7");  // see R2
    // Cycles spent in the delay phase, counted apart from the sequencer's own counter
    logic [CNT_W-1:0] wait_len_q, wait_len_d;
    always_comb begin
        wait_len_d = wait_len_q;
        if (CE) begin
            wait_len_d = (ramp_q == RAMP_WAIT) ? wait_len_q + 1'b1 : '0;
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            wait_len_q <= '0;
        end else begin
            wait_len_q <= wait_len_d;
        end
    end
    property p_delay_len;
        @(posedge REF_CLK) disable iff (SRST)
        $rose(TX_RAMP_ACTIVE) |-> wait_len_q == CNT_W'((32'(tx_q.ramp) + 32'd1) * RAMP_STEP_CYC);
    endproperty
    a_delay_len: assert property (p_delay_len) else $error("ramp delay not as programmed");  // see R3
    property p_ramp_len;
        @(posedge REF_CLK) disable iff (SRST || !CE)
        ($rose(TX_RAMP_ACTIVE) ##1 (txen_sync_q[1] && CE) [*8]) |-> ##[1:24] TX_OUTPUT_ON;
    endproperty
    a_ramp_len: assert property (p_ramp_len) else $error("ramp exceeded one microsecond");  // see R4
    property p_test_leak;
        @(posedge REF_CLK) disable iff (SRST)
        test_q |-> leak_view == leak_pair_t'({tx_q.q, tx_q.i});
    endproperty
    a_test_leak: assert property (p_test_leak) else $error("test mode offsets not from register");  // see R5
    property p_norm_leak;
        @(posedge REF_CLK) disable iff (SRST)
        (rd_go && !test_q && idx == IDX_TX_SETTINGS) |=> READDATA[19:10] == $past(CAL_LEAK);
    endproperty
    a_norm_leak: assert property (p_norm_leak) else $error("normal read not calibrated offset");  // see R6
    property p_off_zero;
        @(posedge REF_CLK) disable iff (SRST)
        !leak_view.i.on |-> I_LEAK_OFFSET_STEPS == 5'sh00;
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("disabled I offset not zero");  // see R7
    property p_band;
        @(posedge REF_CLK) disable iff (SRST)
        (rd_go && !test_q && idx == IDX_OSC_BAND) |=> READDATA[3:0] == $past(CAL_BAND);
    endproperty
    a_band: assert property (p_band) else $error("normal band read wrong");  // see R11
    property p_err;
        @(posedge REF_CLK) disable iff (SRST)
        (CE && CAL_ERROR) |=> vcerr_q;
    endproperty
    a_err: assert property (p_err) else $error("calibration error not flagged");  // see R14
    property p_top_zero;
        @(posedge REF_CLK) disable iff (SRST)
        (rd_go && idx == IDX_TX_SETTINGS) |=> READDATA[23:20] == 4'h0;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("bits 20-23 not zero");  // see R15
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the transmitter and oscillator settings bank
`timescale 1ns/100ps
module tb_top
    import txvco_pkg::*;
;
    logic ref_clk, srst, rd, wr, irq, waitreq, pin, cal_done, cal_error, ramp_act, out_on, ce;
    logic [3:0] be;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata, got;
    leak_pair_t cal_leak;
    logic [3:0] cal_band, lo_gain, hi_gain, band;
    logic signed [4:0] i_steps, q_steps;
    logic [4:0] codes [6] = '{5'h0F, 5'h10, 5'h18, 5'h11, 5'h17, 5'h1F};
    int err_count, n_checks, n, lo;

    tx_and_vco_settings_regs uut (.REF_CLK(ref_clk), .SRST(srst), .CE(ce), .ADDRESS(addr), .READ(rd),
        .WRITE(wr), .BYTEENABLE(be), .WRITEDATA(wdata), .READDATA(rdata), .WAITREQUEST(waitreq), .IRQ(irq),
        .TX_ENABLE_PIN(pin), .CAL_LEAK(cal_leak), .CAL_BAND(cal_band), .CAL_DONE(cal_done),
        .CAL_ERROR(cal_error), .LOW_POWER_TX_OUTPUT_GAIN(lo_gain), .HIGH_POWER_TX_OUTPUT_GAIN(hi_gain),
        .I_LEAK_OFFSET_STEPS(i_steps), .Q_LEAK_OFFSET_STEPS(q_steps), .OSCILLATOR_BAND(band),
        .TX_RAMP_ACTIVE(ramp_act), .TX_OUTPUT_ON(out_on));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask

    task automatic timeout();
        err_count++;
        $display("ERROR at %0t: wait limit got %0h expected %0h", $time, 0, 1);
        results();
    endtask

    // Values seen as the edge wakes us are those the slave sampled at that edge
    task automatic wait_ready();
        for (int k = 0; k < 50; k++) begin
            @(posedge ref_clk);
            if (waitreq === 1'b0) begin
                got = rdata;
                return;
            end
        end
        timeout();
    endtask

    task automatic bus_write(input logic [3:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= {idx, 2'b00};
        wdata <= d;
        wr <= 1'b1;
        wait_ready();
        wr <= 1'b0;
    endtask

    task automatic bus_read(input logic [3:0] idx, input logic [31:0] e);
        @(posedge ref_clk);
        addr <= {idx, 2'b00};
        rd <= 1'b1;
        wait_ready();
        rd <= 1'b0;
        check(got, e);
    endtask

    function automatic logic [4:0] steps(input logic [4:0] c);
        logic [4:0] m;
        m = {2'b00, c[2:0]} + 5'h1;
        if (!c[4]) return 5'h00;
        return c[3] ? -m : m;
    endfunction

    initial begin
        srst = 1'b1;
        {rd, wr, pin, cal_done, cal_error} = '0;
        ce = 1'b1;
        be = 4'hF;
        addr = '0;
        wdata = '0;
        cal_leak = 10'h325;
        cal_band = 4'hA;
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        bus_read(IDX_TX_SETTINGS, {12'h0, cal_leak, 10'h00F});
        bus_read(IDX_CTRL, 32'h0);
        bus_read(IDX_IRQ_STATUS, 32'h0);
        bus_read(IDX_IRQ_MASK, 32'h0);
        @(negedge ref_clk);
        check({24'h0, lo_gain, hi_gain}, 32'hF0);
        // Normal mode: offset bits are not writable and read the calibration inputs
        bus_write(IDX_TX_SETTINGS, 32'hFFFFFF5A);
        bus_read(IDX_TX_SETTINGS, {12'h0, cal_leak, 10'h35A});
        @(negedge ref_clk);
        check({24'h0, hi_gain, lo_gain}, 32'h5A);
        check({27'h0, i_steps}, {27'h0, steps(cal_leak.i)});
        check({27'h0, q_steps}, {27'h0, steps(cal_leak.q)});
        bus_read(IDX_OSC_BAND, 32'h0A);
        bus_write(IDX_OSC_BAND, 32'h3);
        @(negedge ref_clk);
        check({28'h0, band}, 32'hA);
        bus_read(4'h5, 32'h0);
        bus_write(4'h5, 32'hFFFFFFFF);
        bus_read(IDX_TX_SETTINGS, {12'h0, cal_leak, 10'h35A});
        // Byte lanes: lanes 1-3 are written, clearing the ramp; the gain lane keeps its value
        be <= 4'hE;
        bus_write(IDX_TX_SETTINGS, 32'h000000FF);
        be <= 4'hF;
        bus_read(IDX_TX_SETTINGS, {12'h0, cal_leak, 10'h05A});
        // Test mode: offsets and band come from the register
        bus_write(IDX_CTRL, 32'h1);
        for (int k = 0; k < 6; k++) begin
            bus_write(IDX_TX_SETTINGS, {8'h0, 4'hF, codes[(k + 1) % 6], codes[k], 2'b00, 8'hA5});
            @(negedge ref_clk);
            check({27'h0, i_steps}, {27'h0, steps(codes[k])});
            check({27'h0, q_steps}, {27'h0, steps(codes[(k + 1) % 6])});
            check({24'h0, hi_gain, lo_gain}, 32'hA5);
            bus_read(IDX_TX_SETTINGS, {12'h0, codes[(k + 1) % 6], codes[k], 2'b00, 8'hA5});
        end
        bus_write(IDX_OSC_BAND, 32'h3);
        @(negedge ref_clk);
        check({28'h0, band}, 32'h3);
        bus_read(IDX_OSC_BAND, 32'h03);
        // Calibration failure: sticky flag, interrupt, then cleared by a good calibration
        @(posedge ref_clk);
        cal_error <= 1'b1;
        @(posedge ref_clk);
        cal_error <= 1'b0;
        bus_read(IDX_OSC_BAND, 32'h13);
        bus_read(IDX_IRQ_STATUS, 32'h1);
        @(negedge ref_clk);
        check({31'h0, irq}, 32'h0);
        bus_write(IDX_IRQ_MASK, 32'h1);
        @(negedge ref_clk);
        check({31'h0, irq}, 32'h1);
        @(posedge ref_clk);
        cal_done <= 1'b1;
        @(posedge ref_clk);
        cal_done <= 1'b0;
        bus_read(IDX_OSC_BAND, 32'h03);
        bus_write(IDX_IRQ_STATUS, 32'h1);
        @(negedge ref_clk);
        check({31'h0, irq}, 32'h0);
        // A calibration error pulse while the clock enable is low leaves all state frozen
        @(posedge ref_clk);
        ce <= 1'b0;
        cal_error <= 1'b1;
        @(posedge ref_clk);
        cal_error <= 1'b0;
        @(posedge ref_clk);
        ce <= 1'b1;
        bus_read(IDX_OSC_BAND, 32'h03);
        bus_read(IDX_IRQ_STATUS, 32'h0);
        // Ramp sequence for every delay code; the window allows for the pin synchroniser
        for (int c = 0; c < 4; c++) begin
            bus_write(IDX_TX_SETTINGS, 32'h0A5 | (c << 8));
            pin <= 1'b1;
            for (n = 0; ramp_act !== 1'b1; n++) begin
                if (n > 300) timeout();
                @(negedge ref_clk);
            end
            lo = (c + 1) * RAMP_STEP_CYC;
            check({31'h0, (n >= lo && n <= lo + 5)}, 32'h1);
            for (n = 0; ramp_act === 1'b1; n++) begin
                if (n > 100) timeout();
                @(negedge ref_clk);
            end
            check(n, RAMP_TIME_CYC);
            check({31'h0, out_on}, 32'h1);
            bus_read(IDX_IRQ_STATUS, 32'h2);
            if (c == 3) begin
                bus_write(IDX_IRQ_MASK, 32'h2);
                @(negedge ref_clk);
                check({31'h0, irq}, 32'h1);
            end
            bus_write(IDX_IRQ_STATUS, 32'h2);
            @(negedge ref_clk);
            check({31'h0, irq}, 32'h0);
            @(posedge ref_clk);
            pin <= 1'b0;
            repeat (5) @(negedge ref_clk);
            check({30'h0, out_on, ramp_act}, 32'h0);
        end
        // Divider and compensation words belong to another bank
        results();
    end
endmodule
